// [pkg/pmrc_pkg.sv]
package pmrc_pkg;
  // ----------------------------------------
  // Register word offsets (byte addresses = index * 4)
  // ----------------------------------------
  localparam logic [7:0] PWR_CTRL_IDX = 8'h87;
  localparam logic [7:0] RST_SRC_IDX = 8'h88;
  localparam logic [7:0] MON_CTRL_IDX = 8'h89;
  localparam logic [7:0] STATUS_IDX = 8'h8A;
  localparam logic [7:0] FLASH_CMD_IDX = 8'h8B;
  localparam int ADDR_W = 10;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PC_IDLE_BIT = 0;
  localparam int PC_STOP_BIT = 1;
  localparam int PC_GF_LSB = 2;
  localparam int RS_POR_BIT = 1;
  localparam int RS_FLERR_BIT = 6;
  localparam int RS_SWRST_BIT = 4;
  localparam int MC_EN_BIT = 7;
  localparam int MC_STAT_BIT = 6;
  localparam int MC_LVL_BIT = 5;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [5:0] GF_RESET = 6'h00;
  localparam logic [7:0] PORT_LATCH_RESET = 8'hFF;
  localparam logic [15:0] FETCH_RESET = 16'h0000;
  localparam logic [3:0] WDT_DIV = 4'hC;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int POR_DELAY_US = 100;
  localparam int POR_DELAY_CYC = POR_DELAY_US * CLK_MHZ;
  localparam int RST_STRETCH_CYC = 4;

  typedef enum logic [3:0] {
    PM_RESET = 4'h1,
    PM_RUN = 4'h2,
    PM_IDLE = 4'h4,
    PM_STOP = 4'h8
  } pmrc_mode_t;

  typedef struct packed {
    logic cpuRun;
    logic cpuClkEn;
    logic oscEn;
    logic periphClkEn;
  } pmrc_clk_t;
endpackage

// [rtl/pmrc_wdt_div.sv]
`timescale 1ns/1ps
module pmrc_wdt_div #(
  parameter logic [3:0] DIV = 4'hC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Control
  input wire logic clear,
  input wire logic run,
  output logic tick
);
  logic [3:0] cnt_r;
  wire logic wrap = (cnt_r == DIV - 4'h1);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 4'h0;
      tick <= 1'b0;
    end else if (clear) begin
      cnt_r <= 4'h0;
      tick <= 1'b0;
    end else begin
      tick <= run && wrap;
      if (run) begin
        cnt_r <= wrap ? 4'h0 : cnt_r + 4'h1;
      end
    end
  end
endmodule

// [rtl/pmrc_top.sv]
// Function
// - Power control bits 7:2 are six software flags with no hardware effect.
// - Writing stop bit enters stop mode, oscillator halted; bit reads zero.
// - Writing idle bit gates CPU clock only; peripherals run; reads zero.
// - Reset halts execution, resets registers, forces ports, disables interrupts and timers.
// - Reset keeps data memory contents; only stack pointer is reset.
// - During reset port latches are 0xFF open-drain with weak pullups on.
// - Supply-monitor and power-on resets drive reset pin low throughout reset.
// - Leaving reset clears program counter, selects internal oscillator, fetches 0x0000.
// - After any reset watchdog is enabled, clocked by system clock over 12.
// - Power-up holds reset until supply above threshold, then a power-on delay.
// - Power-on exit sets power-on flag bit 1; other flags then indeterminate.
// - Any non power-on reset clears the power-on flag.
// - Monitor enabled by power-on reset; other resets keep its state.
// - Supply below threshold drives reset pin low and holds core in reset.
// - Flash erase or write without monitor enabled at high level forces reset.
// - Release from monitor reset has no power-on delay.
// - High threshold may hold reset until power-on, which forces low threshold.
// - Monitor register: enable bit 7, status bit 6 read-only, level bit 5.
`timescale 1ns/1ps
module pmrc_top #(
  parameter int POR_CYC = pmrc_pkg::POR_DELAY_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [pmrc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic [1:0] avs_response,
  output logic avs_waitrequest,
  // Supply and wake inputs
  input wire logic supplyAboveLow,
  input wire logic supplyAboveHigh,
  input wire logic wakeIrq,
  // Reset pin, open drain
  input wire logic rstPinIn,
  output logic rstPinOut,
  output logic rstPinOe,
  // Core controls
  output logic coreRst,
  output logic cpuClkEn,
  output logic periphClkEn,
  output logic intOscEn,
  output logic [15:0] fetchAddr,
  output logic [7:0] portLatch,
  output logic portOpenDrain,
  output logic weakPullEn,
  output logic irqTimerEn,
  output logic wdtEnable,
  output logic wdtTick
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  pmrc_pkg::pmrc_mode_t mode_r, mode_nxt;
  logic [5:0] genFlags_r;
  logic monEn_r, monLvl_r, porFlag_r, monSrc_r, flErr_r, swRst_r;
  logic porDone_r, wasPor_r, reqFlash_r;
  logic [31:0] porCnt_r;
  logic [2:0] stretch_r;
  logic ack_r;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire logic [7:0] wIdx = avs_address[pmrc_pkg::ADDR_W-1:2];
  wire logic acc = (avs_read || avs_write) && !ack_r;
  // Writes land only on the edge that ends the wait
  wire logic wrLo = avs_write && ack_r && avs_byteenable[0];
  wire logic selPc = (wIdx == pmrc_pkg::PWR_CTRL_IDX);
  wire logic selRs = (wIdx == pmrc_pkg::RST_SRC_IDX);
  wire logic selMc = (wIdx == pmrc_pkg::MON_CTRL_IDX);
  wire logic selSt = (wIdx == pmrc_pkg::STATUS_IDX);
  wire logic selFl = (wIdx == pmrc_pkg::FLASH_CMD_IDX);
  wire logic mapped = selPc || selRs || selMc || selSt || selFl;
  wire logic wrPc = wrLo && selPc && !coreRst;
  wire logic wrRs = wrLo && selRs && !coreRst;
  wire logic wrMc = wrLo && selMc && !coreRst;
  wire logic wrFl = wrLo && selFl && !coreRst;

  // ----------------------------------------
  // Reset causes
  // ----------------------------------------
  wire logic supplyOk = monLvl_r ? supplyAboveHigh : supplyAboveLow;
  // Monitor resets only when enabled and selected as a source
  wire logic monTrip = monEn_r && monSrc_r && !supplyOk;
  wire logic porHold = !porDone_r;
  wire logic flashBad = wrFl && avs_writedata[0] && !(monEn_r && monLvl_r);
  wire logic swReq = wrRs && avs_writedata[pmrc_pkg::RS_SWRST_BIT];
  wire logic anyRst = porHold || monTrip || (stretch_r != 3'h0);
  wire logic pinDrive = porHold || monTrip;
  // Own drive on the pin must not read back as an external reset
  wire logic extRst = !rstPinIn && !rstPinOe;
  wire logic stopReq = wrPc && avs_writedata[pmrc_pkg::PC_STOP_BIT];
  wire logic idleReq = wrPc && avs_writedata[pmrc_pkg::PC_IDLE_BIT];

  // ----------------------------------------
  // Power-on delay, restarts on every power-on hold
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      porCnt_r <= 32'h0;
      porDone_r <= 1'b0;
    end else if (!porDone_r) begin
      if (!supplyAboveLow) begin
        porCnt_r <= 32'h0;
      end else if (porCnt_r >= 32'(POR_CYC - 1)) begin
        porDone_r <= 1'b1;
      end else begin
        porCnt_r <= porCnt_r + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // Reset stretch for flash error, software and external pin causes
  // ----------------------------------------
  // Monitor trip adds no delay; it releases when supply recovers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stretch_r <= 3'h0;
    end else if (flashBad || swReq || extRst) begin
      stretch_r <= 3'(pmrc_pkg::RST_STRETCH_CYC);
    end else if (stretch_r != 3'h0) begin
      stretch_r <= stretch_r - 3'h1;
    end
  end

  // ----------------------------------------
  // Mode machine
  // ----------------------------------------
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      pmrc_pkg::PM_RESET: if (!anyRst) mode_nxt = pmrc_pkg::PM_RUN;
      pmrc_pkg::PM_RUN: begin
        if (stopReq) begin
          mode_nxt = pmrc_pkg::PM_STOP;
        end else if (idleReq) begin
          mode_nxt = pmrc_pkg::PM_IDLE;
        end
      end
      pmrc_pkg::PM_IDLE: if (wakeIrq) mode_nxt = pmrc_pkg::PM_RUN;
      pmrc_pkg::PM_STOP: mode_nxt = mode_r;
      default: mode_nxt = pmrc_pkg::PM_RESET;
    endcase
    if (anyRst || flashBad || swReq) begin
      mode_nxt = pmrc_pkg::PM_RESET;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= pmrc_pkg::PM_RESET;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      genFlags_r <= pmrc_pkg::GF_RESET;
    end else if (coreRst) begin
      genFlags_r <= pmrc_pkg::GF_RESET;
    end else if (wrPc) begin
      genFlags_r <= avs_writedata[7:2];
    end
  end

  // Monitor state persists across all but power-on reset
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      monEn_r <= 1'b1;
      monLvl_r <= 1'b0;
      monSrc_r <= 1'b1;
      wasPor_r <= 1'b1;
    end else if (porHold) begin
      monEn_r <= 1'b1;
      monLvl_r <= 1'b0;
      monSrc_r <= 1'b1;
      wasPor_r <= 1'b1;
    end else begin
      if (wrMc) begin
        monEn_r <= avs_writedata[pmrc_pkg::MC_EN_BIT];
        monLvl_r <= avs_writedata[pmrc_pkg::MC_LVL_BIT];
      end
      if (wrRs) begin
        monSrc_r <= avs_writedata[pmrc_pkg::RS_POR_BIT];
      end
      if (flashBad || swReq || monTrip || extRst) begin
        wasPor_r <= 1'b0;
      end
    end
  end

  // Power-on flag is resolved on the way out of reset; flash and software flags set on request
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      porFlag_r <= 1'b0;
      flErr_r <= 1'b0;
      swRst_r <= 1'b0;
    end else if (mode_r == pmrc_pkg::PM_RESET && !anyRst) begin
      porFlag_r <= wasPor_r;
    end else begin
      if (flashBad) flErr_r <= 1'b1;
      else if (porHold) flErr_r <= 1'b0;
      if (swReq) swRst_r <= 1'b1;
      else if (porHold || flashBad) swRst_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read mux and bus answer
  // ----------------------------------------
  wire logic [7:0] rdPc = {genFlags_r, 2'b00};
  wire logic [7:0] rdRs = {1'b0, flErr_r, 1'b0, swRst_r, 2'b00, porFlag_r, 1'b0};
  wire logic [7:0] rdMc = {monEn_r, supplyOk, monLvl_r, 5'h00};
  wire logic [7:0] rdSt = {4'h0, mode_r};
  wire logic [7:0] rdMux = selPc ? rdPc : selRs ? rdRs : selMc ? rdMc : selSt ? rdSt : 8'h00;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
      avs_readdata <= 32'h0;
      avs_response <= 2'h0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_r <= acc;
      avs_waitrequest <= !acc;
      if (acc) begin
        avs_readdata <= {24'h0, rdMux};
        avs_response <= mapped ? 2'h0 : 2'h2;
      end
    end
  end

  // ----------------------------------------
  // Core-facing outputs
  // ----------------------------------------
  wire logic inRst = (mode_nxt == pmrc_pkg::PM_RESET);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      coreRst <= 1'b1;
      rstPinOut <= 1'b0;
      rstPinOe <= 1'b1;
      cpuClkEn <= 1'b0;
      periphClkEn <= 1'b0;
      intOscEn <= 1'b1;
      fetchAddr <= pmrc_pkg::FETCH_RESET;
      portLatch <= pmrc_pkg::PORT_LATCH_RESET;
      portOpenDrain <= 1'b1;
      weakPullEn <= 1'b1;
      irqTimerEn <= 1'b0;
      wdtEnable <= 1'b1;
    end else begin
      coreRst <= inRst;
      rstPinOut <= 1'b0;
      rstPinOe <= pinDrive || monTrip;
      cpuClkEn <= (mode_nxt == pmrc_pkg::PM_RUN);
      periphClkEn <= (mode_nxt == pmrc_pkg::PM_RUN) || (mode_nxt == pmrc_pkg::PM_IDLE);
      intOscEn <= (mode_nxt != pmrc_pkg::PM_STOP);
      irqTimerEn <= !inRst && (mode_nxt != pmrc_pkg::PM_STOP);
      if (inRst) begin
        fetchAddr <= pmrc_pkg::FETCH_RESET;
        portLatch <= pmrc_pkg::PORT_LATCH_RESET;
        portOpenDrain <= 1'b1;
        wdtEnable <= 1'b1;
      end
      weakPullEn <= 1'b1;
    end
  end

  pmrc_wdt_div #(
    .DIV(pmrc_pkg::WDT_DIV)
  ) pmrc_wdt_div_inst (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clear(coreRst),
    .run(wdtEnable && (mode_r != pmrc_pkg::PM_STOP)),
    .tick(wdtTick)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_stop_wins: assert property (@(posedge core_clk) disable iff (!arst_n)
    (mode_r == pmrc_pkg::PM_RUN && stopReq && idleReq && !anyRst) |=> mode_r == pmrc_pkg::PM_STOP)
    else $error("stop and idle together did not enter stop");
  a_stop_osc_off: assert property (@(posedge core_clk) disable iff (!arst_n)
    (mode_r == pmrc_pkg::PM_STOP) |-> !intOscEn && !cpuClkEn)
    else $error("oscillator running in stop");
  a_idle_periph_on: assert property (@(posedge core_clk) disable iff (!arst_n)
    (mode_r == pmrc_pkg::PM_IDLE) |-> !cpuClkEn && periphClkEn)
    else $error("idle clock gating wrong");
  a_reads_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
    (ack_r && selPc) |-> avs_readdata[1:0] == 2'b00)
    else $error("mode select bits read nonzero");
  a_flags_kept: assert property (@(posedge core_clk) disable iff (!arst_n)
    (wrPc && !anyRst) |=> genFlags_r == $past(avs_writedata[7:2]))
    else $error("general flags not stored");
  a_pin_por: assert property (@(posedge core_clk) disable iff (!arst_n)
    porHold |=> rstPinOe && !rstPinOut)
    else $error("reset pin not driven during power-on");
  a_flash_reset: assert property (@(posedge core_clk) disable iff (!arst_n)
    flashBad |=> coreRst ##1 flErr_r)
    else $error("flash error reset missing");
  a_por_low_lvl: assert property (@(posedge core_clk) disable iff (!arst_n)
    porHold |=> monEn_r && !monLvl_r)
    else $error("power-on did not restore monitor");
  a_reset_ports: assert property (@(posedge core_clk) disable iff (!arst_n)
    coreRst |-> portLatch == pmrc_pkg::PORT_LATCH_RESET && portOpenDrain && weakPullEn)
    else $error("ports not forced in reset");
  a_no_por_delay: assert property (@(posedge core_clk) disable iff (!arst_n)
    (mode_r == pmrc_pkg::PM_RESET && porDone_r && monTrip ##1 !monTrip && stretch_r == 3'h0)
    |=> mode_r == pmrc_pkg::PM_RUN)
    else $error("monitor release delayed");
  a_trip_holds: assert property (@(posedge core_clk) disable iff (!arst_n)
    monTrip |=> coreRst && rstPinOe)
    else $error("monitor trip did not hold reset");
  a_por_holds: assert property (@(posedge core_clk) disable iff (!arst_n)
    porHold |=> coreRst && !cpuClkEn)
    else $error("core released during power-on hold");
  a_mon_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!porHold && !wrMc) |=> monEn_r == $past(monEn_r))
    else $error("monitor enable changed without write");
  a_wdt_on_exit: assert property (@(posedge core_clk) disable iff (!arst_n)
    $fell(coreRst) |-> wdtEnable)
    else $error("watchdog not enabled on reset exit");
  a_por_flag_set: assert property (@(posedge core_clk) disable iff (!arst_n)
    (mode_r == pmrc_pkg::PM_RESET && !anyRst && wasPor_r) |=> porFlag_r)
    else $error("power-on flag not set on exit");
endmodule

// [verification/power_mode_and_reset_control_tb.sv]
`timescale 1ns/1ps
module power_mode_and_reset_control_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int POR = 40;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [pmrc_pkg::ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic [1:0] avs_response;
  logic avs_waitrequest;
  logic supplyAboveLow = 1'b0;
  logic supplyAboveHigh = 1'b1;
  logic wakeIrq = 1'b0;
  logic rstPinOut, rstPinOe, coreRst, cpuClkEn, periphClkEn, intOscEn;
  logic portOpenDrain, weakPullEn, irqTimerEn, wdtEnable, wdtTick;
  logic [15:0] fetchAddr;
  logic [7:0] portLatch;
  logic [31:0] rd;
  int miscompares = 0;
  int total_checks = 0;
  int n;
  // Open-drain pin with pull-up
  wire rstPin = rstPinOe ? rstPinOut : 1'b1;

  always #25 core_clk = ~core_clk;

  pmrc_top #(.POR_CYC(POR)) pmrc_top_inst (
    .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_response(avs_response),
    .avs_waitrequest(avs_waitrequest), .supplyAboveLow(supplyAboveLow),
    .supplyAboveHigh(supplyAboveHigh), .wakeIrq(wakeIrq), .rstPinIn(rstPin),
    .rstPinOut(rstPinOut), .rstPinOe(rstPinOe), .coreRst(coreRst), .cpuClkEn(cpuClkEn),
    .periphClkEn(periphClkEn), .intOscEn(intOscEn), .fetchAddr(fetchAddr),
    .portLatch(portLatch), .portOpenDrain(portOpenDrain), .weakPullEn(weakPullEn),
    .irqTimerEn(irqTimerEn), .wdtEnable(wdtEnable), .wdtTick(wdtTick)
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    k = 0;
    @(posedge core_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, wd};
    avs_byteenable <= 4'h1;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 100);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 100) chk("waitrequest", 32'h0, 32'h1);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd);
  endtask

  task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] mask,
                       input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(what, {24'h0, exp}, rd & {24'h0, mask});
  endtask

  // Cycles until core leaves reset, bounded
  task automatic wait_rel();
    n = 0;
    while (coreRst !== 1'b0 && n < 500) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 500) chk("release", 32'h0, 32'h1);
  endtask

  task automatic do_por();
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    wait_rel();
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #1ms;
    miscompares++;
    finish_test();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    chk("coreRst", 32'h1, {31'h0, coreRst});
    chk("rstPin", 32'h0, {31'h0, rstPin});
    chk("portLatch", 32'hFF, {24'h0, portLatch});
    chk("pullOd", 32'h3, {30'h0, portOpenDrain, weakPullEn});
    chk("wdtEnable", 32'h1, {31'h0, wdtEnable});
    chk("oscCpu", 32'h2, {30'h0, intOscEn, cpuClkEn});
    chk("irqTimerEn", 32'h0, {31'h0, irqTimerEn});
    arst_n <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk("holdLowSupply", 32'h1, {31'h0, coreRst});
    supplyAboveLow <= 1'b1;
    wait_rel();
    chk("porDelay", 32'h1, {31'h0, n >= POR});
    chk("fetchAddr", 32'h0, {16'h0, fetchAddr});
    chk("weakPullAfter", 32'h1, {31'h0, weakPullEn});
    rdchk("porFlag", pmrc_pkg::RST_SRC_IDX, 8'h02, 8'h02);
    rdchk("monCtrl", pmrc_pkg::MON_CTRL_IDX, 8'hE0, 8'hC0);
    rdchk("pcReset", pmrc_pkg::PWR_CTRL_IDX, 8'hFF, 8'h00);
    $display("test power_on done");

    wr(pmrc_pkg::PWR_CTRL_IDX, 8'hFC);
    rdchk("flags", pmrc_pkg::PWR_CTRL_IDX, 8'hFF, 8'hFC);
    n = 0;
    repeat (120) begin
      @(posedge core_clk);
      n += int'(wdtTick === 1'b1);
    end
    chk("wdtTicks", 32'hA, n);
    wr(pmrc_pkg::PWR_CTRL_IDX, 8'hA9);
    repeat (3) @(posedge core_clk);
    chk("idleClk", 32'h1, {30'h0, cpuClkEn, periphClkEn});
    chk("idleTimers", 32'h1, {31'h0, irqTimerEn});
    rdchk("idleRead", pmrc_pkg::PWR_CTRL_IDX, 8'hFF, 8'hA8);
    rdchk("idleMode", pmrc_pkg::STATUS_IDX, 8'h0F, {4'h0, pmrc_pkg::PM_IDLE});
    @(posedge core_clk);
    wakeIrq <= 1'b1;
    @(posedge core_clk);
    wakeIrq <= 1'b0;
    rdchk("wakeMode", pmrc_pkg::STATUS_IDX, 8'h0F, {4'h0, pmrc_pkg::PM_RUN});
    bus(1'b0, 8'h40, 8'h00);
    chk("unmapped", 32'h2, {30'h0, avs_response});
    chk("unmappedData", 32'h0, rd);
    $display("test power_control done");

    @(posedge core_clk);
    supplyAboveLow <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk("tripCore", 32'h1, {31'h0, coreRst});
    chk("tripPin", 32'h0, {31'h0, rstPin});
    supplyAboveLow <= 1'b1;
    wait_rel();
    chk("noPorDelay", 32'h1, {31'h0, n < POR});
    rdchk("porFlagClr", pmrc_pkg::RST_SRC_IDX, 8'h02, 8'h00);
    $display("test monitor_trip done");

    wr(pmrc_pkg::MON_CTRL_IDX, 8'h00);
    wr(pmrc_pkg::FLASH_CMD_IDX, 8'h01);
    repeat (2) @(posedge core_clk);
    chk("flashErrRst", 32'h1, {31'h0, coreRst});
    wait_rel();
    rdchk("flashFlag", pmrc_pkg::RST_SRC_IDX, 8'h42, 8'h40);
    rdchk("monKept", pmrc_pkg::MON_CTRL_IDX, 8'hA0, 8'h00);
    wr(pmrc_pkg::MON_CTRL_IDX, 8'h80);
    wr(pmrc_pkg::RST_SRC_IDX, 8'h02);
    wr(pmrc_pkg::MON_CTRL_IDX, 8'hA0);
    wr(pmrc_pkg::FLASH_CMD_IDX, 8'h01);
    repeat (20) @(posedge core_clk);
    chk("flashOk", 32'h0, {31'h0, coreRst});
    rdchk("monHigh", pmrc_pkg::MON_CTRL_IDX, 8'hE0, 8'hE0);
    wr(pmrc_pkg::RST_SRC_IDX, 8'h00);
    supplyAboveLow <= 1'b0;
    wr(pmrc_pkg::MON_CTRL_IDX, 8'hC0);
    rdchk("statRo", pmrc_pkg::MON_CTRL_IDX, 8'hE0, 8'h80);
    supplyAboveLow <= 1'b1;
    wr(pmrc_pkg::RST_SRC_IDX, 8'h02);
    wr(pmrc_pkg::MON_CTRL_IDX, 8'h80);
    $display("test flash done");

    wr(pmrc_pkg::PWR_CTRL_IDX, 8'hFC);
    wr(pmrc_pkg::RST_SRC_IDX, 8'h12);
    repeat (2) @(posedge core_clk);
    wait_rel();
    rdchk("swFlags", pmrc_pkg::PWR_CTRL_IDX, 8'hFF, 8'h00);
    rdchk("swSrc", pmrc_pkg::RST_SRC_IDX, 8'h12, 8'h10);
    rdchk("swMon", pmrc_pkg::MON_CTRL_IDX, 8'h80, 8'h80);
    chk("swWdt", 32'h1, {31'h0, wdtEnable});
    $display("test soft_reset done");

    wr(pmrc_pkg::MON_CTRL_IDX, 8'hA0);
    wr(pmrc_pkg::PWR_CTRL_IDX, 8'h03);
    repeat (3) @(posedge core_clk);
    chk("stopClk", 32'h0, {30'h0, intOscEn, cpuClkEn});
    chk("stopNoRst", 32'h0, {31'h0, coreRst});
    chk("stopTimers", 32'h0, {31'h0, irqTimerEn});
    do_por();
    rdchk("porLevel", pmrc_pkg::MON_CTRL_IDX, 8'hE0, 8'hC0);
    rdchk("porFlag2", pmrc_pkg::RST_SRC_IDX, 8'h02, 8'h02);
    chk("runOsc", 32'h3, {30'h0, intOscEn, cpuClkEn});
    $display("test stop done");
    finish_test();
  end
endmodule
